// [ptu_params.svh]
`ifndef PTU_PARAMS_SVH
`define PTU_PARAMS_SVH

// ==========================================================================
// Register offsets on the byte-wide register port.
// ==========================================================================
`define PTU_OFS_CONTROL_0        4'h0
`define PTU_OFS_CONTROL_1        4'h1
`define PTU_OFS_COUNTER_LOW      4'h2
`define PTU_OFS_COUNTER_HIGH     4'h3
`define PTU_OFS_COMPARE_A_LOW    4'h4
`define PTU_OFS_COMPARE_A_HIGH   4'h5
`define PTU_OFS_COMPARE_P_LOW    4'h6
`define PTU_OFS_COMPARE_P_HIGH   4'h7
`define PTU_OFS_FLAGS            4'h8

// ==========================================================================
// Field positions.
// ==========================================================================
`define PTU_C0_PAUSE_BIT         7
`define PTU_C0_CLK_SEL_MSB       6
`define PTU_C0_CLK_SEL_LSB       4
`define PTU_C0_ON_BIT            3
`define PTU_C1_MODE_MSB          7
`define PTU_C1_MODE_LSB          6
`define PTU_C1_PIN_FN_MSB        5
`define PTU_C1_PIN_FN_LSB        4
`define PTU_C1_INIT_LEVEL_BIT    3
`define PTU_C1_POL_INV_BIT       2
`define PTU_C1_CAPT_SEL_BIT      1
`define PTU_C1_CLR_SEL_BIT       0
`define PTU_FLAG_A_BIT           0
`define PTU_FLAG_P_BIT           1

// ==========================================================================
// Encodings, reset values and counts.
// ==========================================================================
`define PTU_MODE_COMPARE         2'h0
`define PTU_MODE_CAPTURE         2'h1
`define PTU_MODE_PWM             2'h2
`define PTU_MODE_TIMER           2'h3
`define PTU_PIN_NONE             2'h0
`define PTU_PIN_LOW              2'h1
`define PTU_PIN_HIGH             2'h2
`define PTU_PIN_TOGGLE           2'h3
`define PTU_CLK_SYS_DIV4         3'h0
`define PTU_CLK_SYS              3'h1
`define PTU_CLK_HIGH_DIV16       3'h2
`define PTU_CLK_HIGH_DIV64       3'h3
`define PTU_CLK_SUB_A            3'h4
`define PTU_CLK_SUB_B            3'h5
`define PTU_CLK_PIN_RISE         3'h6
`define PTU_CLK_PIN_FALL         3'h7
`define PTU_RESET_BYTE           8'h00
`define PTU_RESET_VALUE          10'h000
`define PTU_COUNT_MAX            10'h3ff
`define PTU_FULL_PERIOD          11'h400
`define PTU_DIV4_MASK            6'h03
`define PTU_DIV16_MASK           6'h0f
`define PTU_DIV64_MASK           6'h3f

`endif

// [ptu_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Far side: trigger pin bursts and a free-running sub clock.
module ptu_pin_model (
  input  wire logic i_clock, // System clock.
  input  wire logic i_fire,  // Start one burst of pin edges.
  output logic      o_pin,   // Clock or trigger pin.
  output logic      o_sub    // Sub clock, eight system cycles a period.
);
  logic [5:0] left_ff = 6'h00;
  logic [2:0] div_ff  = 3'h0;
  logic       pin_ff  = 1'b0;
  // Pin rests low between bursts.
  always_ff @(posedge i_clock) begin
    div_ff <= div_ff + 3'h1;
    if (i_fire) begin
      left_ff <= 6'h3f;
    end else if (left_ff != 6'h00) begin
      left_ff <= left_ff - 6'h01;
    end
    pin_ff <= (left_ff != 6'h00) && left_ff[1];
  end
  // Outputs come straight from flops.
  assign o_pin = pin_ff;
  assign o_sub = div_ff[2];
endmodule // ptu_pin_model
`default_nettype wire

// [ptu_pkg.sv]
`include "ptu_params.svh"

package ptu_pkg;

  // Field types of the control registers, counter and bus.
  typedef logic [1:0] ptu_mode_t;
  typedef logic [1:0] ptu_pin_fn_t;
  typedef logic [2:0] ptu_clk_sel_t;
  typedef logic [9:0] ptu_count_t;
  typedef logic [3:0] ptu_addr_t;
  typedef logic [7:0] ptu_byte_t;

  // State of the timer except read_valid_ff, registered in one place.
  typedef struct packed {
    ptu_count_t   count;
    ptu_count_t   compare_a_value;
    ptu_count_t   compare_p_value;
    logic         counter_pause;
    ptu_clk_sel_t clock_source_select;
    logic         counter_on_off;
    ptu_mode_t    mode_select;
    ptu_pin_fn_t  pin_function;
    logic         output_initial_level;
    logic         output_polarity_invert;
    logic         capture_select;
    logic         counter_clear_select;
    logic         compare_a_flag;
    logic         compare_p_flag;
    logic         on_prev;
    logic [5:0]   prescale;
    logic         ext_meta;
    logic         ext_sync;
    logic         ext_prev;
    logic         sub_meta;
    logic         sub_sync;
    logic         sub_prev;
    logic         out_level;
    logic         out_enable;
    ptu_byte_t    read_data;
  } ptu_state_s;

endpackage

// [ptu_timer.sv]
// Overview of operation
// - Counter readable only, split low byte/two bits.
// - Compare A ten bits, byte split, resets zero.
// - Compare P ten bits, byte split, resets zero.
// - Mode field 00 selects compare output.
// - Clear select low: P clears, both flag.
// - Compare P zero: counter overflows instead.
// - Clear select high: A clears, A flag only.
// - Compare A zero: overflow, no A flag.
// - Compare pin changes only on A flag or on rise.
// - P match never moves the output pin.
// - On-bit rising edge loads initial pin level.
// - Mode 11 counts like compare, no pin.
// - Mode 10 PWM: P period, A duty.
// - PWM sets A flag and P flag separately.
// - PWM: level bit, pin function, polarity invert.
// - Period equals P; zero gives 1024 counts.
// - Duty at or above period: full on.
// - Forced pin levels keep PWM counting running.
// - Mode 10 with pin function 11: single pulse.
// - On rise or pin edge starts pulse.
// - Software clear or A match ends pulse.
// - Pulse mode: counter cleared only on rise.
// - Three-bit select picks the counter clock.
// - On rise clears counter; fall holds it.
// - Pause holds the count, then resumes.
`timescale 1ns/1ps
`default_nettype none
`include "ptu_params.svh"

module ptu_timer (
  input  wire logic              i_clock,       // System clock, 50 MHz.
  input  wire logic              i_reset,       // Asynchronous reset, active high.
  input  wire ptu_pkg::ptu_addr_t i_address,    // Register address.
  input  wire ptu_pkg::ptu_byte_t i_write_data, // Register write data.
  input  wire logic              i_write,       // Write strobe, one cycle.
  input  wire logic              i_read,        // Read strobe, one cycle.
  input  wire logic              i_ext_clock_pin, // External clock or trigger pin.
  input  wire logic              i_sub_clock,   // Slow sub clock from outside.
  output logic                   o_read_data_valid, // High in the cycle after a read.
  output ptu_pkg::ptu_byte_t     o_read_data,   // Read data, cycle after the strobe.
  output logic                   o_out_pin,     // Timer output pin level.
  output logic                   o_out_enable,  // High while the timer drives the pin.
  output logic                   o_compare_a_flag, // Sticky compare A flag.
  output logic                   o_compare_p_flag  // Sticky compare P flag.
);

  import ptu_pkg::*;

  // ========================================================================
  // State registers.
  // ========================================================================
  ptu_state_s state_ff;
  ptu_state_s nxt_state;
  logic       read_valid_ff;
  logic       nxt_read_valid;

  // ========================================================================
  // Next-state logic.
  // ========================================================================

  // Everything the timer does is decided here from the registered state.
  always_comb begin
    logic         tick;
    logic         ext_rise;
    logic         ext_fall;
    logic         sub_rise;
    logic         trigger_edge;
    logic         on_rise;
    logic         running;
    logic         compare_like;
    logic         pwm_mode;
    logic         single_pulse;
    logic         a_hit;
    logic         p_hit;
    logic         p_end;
    logic         set_a;
    logic         set_p;
    logic         clear_count;
    logic         hw_clear_on;
    logic         full_duty;
    logic         duty_active;
    logic         wave;
    logic         clear_a;
    logic         clear_p;
    logic [10:0]  period;
    ptu_count_t   p_last;
    ptu_byte_t    read_value;

    nxt_state      = state_ff;
    nxt_read_valid = i_read;
    tick           = 1'b0;
    read_value     = `PTU_RESET_BYTE;
    wave           = 1'b0;

    // Two flops on each outside pin before any logic looks at it.
    nxt_state.ext_meta = i_ext_clock_pin;
    nxt_state.ext_sync = state_ff.ext_meta;
    nxt_state.ext_prev = state_ff.ext_sync;
    nxt_state.sub_meta = i_sub_clock;
    nxt_state.sub_sync = state_ff.sub_meta;
    nxt_state.sub_prev = state_ff.sub_sync;
    ext_rise = state_ff.ext_sync & ~state_ff.ext_prev;
    ext_fall = ~state_ff.ext_sync & state_ff.ext_prev;
    sub_rise = state_ff.sub_sync & ~state_ff.sub_prev;

    // The high clock is taken to be the system clock itself.
    nxt_state.prescale = state_ff.prescale + 6'h01;
    unique case (state_ff.clock_source_select)
      `PTU_CLK_SYS_DIV4: begin
        tick = (state_ff.prescale & `PTU_DIV4_MASK) == `PTU_DIV4_MASK;
      end
      `PTU_CLK_SYS: begin
        tick = 1'b1;
      end
      `PTU_CLK_HIGH_DIV16: begin
        tick = (state_ff.prescale & `PTU_DIV16_MASK) == `PTU_DIV16_MASK;
      end
      `PTU_CLK_HIGH_DIV64: begin
        tick = (state_ff.prescale & `PTU_DIV64_MASK) == `PTU_DIV64_MASK;
      end
      `PTU_CLK_SUB_A, `PTU_CLK_SUB_B: begin
        tick = sub_rise;
      end
      `PTU_CLK_PIN_RISE: begin
        tick = ext_rise;
      end
      `PTU_CLK_PIN_FALL: begin
        tick = ext_fall;
      end
    endcase

    // Mode decode; capture mode is not built and behaves as a timer.
    pwm_mode     = state_ff.mode_select == `PTU_MODE_PWM;
    single_pulse = pwm_mode && (state_ff.pin_function == `PTU_PIN_TOGGLE);
    compare_like = !pwm_mode;

    // The counter moves only on a selected tick while on and not paused.
    on_rise = state_ff.counter_on_off & ~state_ff.on_prev;
    nxt_state.on_prev = state_ff.counter_on_off;
    running = state_ff.counter_on_off && !state_ff.counter_pause && tick
              && !on_rise;

    // Comparator hits; a zero compare value never hits.
    a_hit  = (state_ff.compare_a_value != `PTU_RESET_VALUE)
             && (state_ff.count == state_ff.compare_a_value);
    p_hit  = (state_ff.compare_p_value != `PTU_RESET_VALUE)
             && (state_ff.count == state_ff.compare_p_value);
    // Wrapping subtraction turns a zero period into the full count.
    p_last = state_ff.compare_p_value - 10'h001;
    p_end  = state_ff.count == p_last;

    set_a       = 1'b0;
    set_p       = 1'b0;
    clear_count = 1'b0;
    hw_clear_on = 1'b0;
    if (running) begin
      if (single_pulse) begin
        // Only compare A matters; it ends the pulse and stops the count.
        set_a       = a_hit;
        hw_clear_on = a_hit;
      end else if (pwm_mode) begin
        set_a       = state_ff.count == state_ff.compare_a_value;
        set_p       = p_end;
        clear_count = p_end;
      end else if (state_ff.counter_clear_select) begin
        set_a       = a_hit;
        clear_count = a_hit;
      end else begin
        set_a       = a_hit;
        set_p       = p_hit;
        clear_count = p_hit;
      end
    end

    // Counter update; a natural wrap past the top is the overflow.
    if (on_rise) begin
      nxt_state.count = `PTU_RESET_VALUE;
    end else if (running) begin
      if (clear_count) begin
        nxt_state.count = `PTU_RESET_VALUE;
      end else begin
        nxt_state.count = state_ff.count + 10'h001;
      end
    end

    // Duty compare; a duty at or past the period stays active throughout.
    if (state_ff.compare_p_value == `PTU_RESET_VALUE) begin
      period = `PTU_FULL_PERIOD;
    end else begin
      period = {1'b0, state_ff.compare_p_value};
    end
    full_duty   = {1'b0, state_ff.compare_a_value} >= period;
    duty_active = full_duty || (state_ff.count < state_ff.compare_a_value);

    // Output pin behaviour per mode.
    nxt_state.out_enable = (state_ff.mode_select == `PTU_MODE_COMPARE) || pwm_mode;
    if (single_pulse) begin
      // Active level while the on bit stands, idle level otherwise.
      wave = state_ff.counter_on_off ? state_ff.output_initial_level
                                     : ~state_ff.output_initial_level;
      nxt_state.out_level = wave ^ state_ff.output_polarity_invert;
    end else if (pwm_mode) begin
      // The count runs on even when the pin is forced.
      unique case (state_ff.pin_function)
        `PTU_PIN_NONE: begin
          wave = ~state_ff.output_initial_level;
        end
        `PTU_PIN_LOW: begin
          wave = state_ff.output_initial_level;
        end
        default: begin
          wave = duty_active ? state_ff.output_initial_level
                             : ~state_ff.output_initial_level;
        end
      endcase
      if (!state_ff.counter_on_off) begin
        wave = ~state_ff.output_initial_level;
      end
      nxt_state.out_level = wave ^ state_ff.output_polarity_invert;
    end else if (on_rise) begin
      nxt_state.out_level = state_ff.output_initial_level;
    end else if (set_a && (state_ff.mode_select == `PTU_MODE_COMPARE)) begin
      // Compare P never reaches here, so it never moves the pin.
      unique case (state_ff.pin_function)
        `PTU_PIN_NONE: begin
          nxt_state.out_level = state_ff.out_level;
        end
        `PTU_PIN_LOW: begin
          nxt_state.out_level = 1'b0;
        end
        `PTU_PIN_HIGH: begin
          nxt_state.out_level = 1'b1;
        end
        `PTU_PIN_TOGGLE: begin
          nxt_state.out_level = ~state_ff.out_level;
        end
      endcase
    end

    // Single pulse: an active pin edge switches the timer on by itself.
    if (state_ff.clock_source_select == `PTU_CLK_PIN_FALL) begin
      trigger_edge = ext_fall;
    end else begin
      trigger_edge = ext_rise;
    end
    if (hw_clear_on) begin
      nxt_state.counter_on_off = 1'b0;
    end
    if (single_pulse && trigger_edge && !state_ff.counter_on_off) begin
      nxt_state.counter_on_off = 1'b1;
    end

    // Register writes; a write to the on bit overrides the hardware.
    clear_a = 1'b0;
    clear_p = 1'b0;
    if (i_write) begin
      unique case (i_address)
        `PTU_OFS_CONTROL_0: begin
          nxt_state.counter_pause       = i_write_data[`PTU_C0_PAUSE_BIT];
          nxt_state.clock_source_select =
            i_write_data[`PTU_C0_CLK_SEL_MSB:`PTU_C0_CLK_SEL_LSB];
          nxt_state.counter_on_off      = i_write_data[`PTU_C0_ON_BIT];
        end
        `PTU_OFS_CONTROL_1: begin
          nxt_state.mode_select            = i_write_data[`PTU_C1_MODE_MSB:`PTU_C1_MODE_LSB];
          nxt_state.pin_function           =
            i_write_data[`PTU_C1_PIN_FN_MSB:`PTU_C1_PIN_FN_LSB];
          nxt_state.output_initial_level   = i_write_data[`PTU_C1_INIT_LEVEL_BIT];
          nxt_state.output_polarity_invert = i_write_data[`PTU_C1_POL_INV_BIT];
          nxt_state.capture_select         = i_write_data[`PTU_C1_CAPT_SEL_BIT];
          nxt_state.counter_clear_select   = i_write_data[`PTU_C1_CLR_SEL_BIT];
        end
        `PTU_OFS_COMPARE_A_LOW: begin
          nxt_state.compare_a_value[7:0] = i_write_data;
        end
        `PTU_OFS_COMPARE_A_HIGH: begin
          nxt_state.compare_a_value[9:8] = i_write_data[1:0];
        end
        `PTU_OFS_COMPARE_P_LOW: begin
          nxt_state.compare_p_value[7:0] = i_write_data;
        end
        `PTU_OFS_COMPARE_P_HIGH: begin
          nxt_state.compare_p_value[9:8] = i_write_data[1:0];
        end
        `PTU_OFS_FLAGS: begin
          clear_a = i_write_data[`PTU_FLAG_A_BIT];
          clear_p = i_write_data[`PTU_FLAG_P_BIT];
        end
        default: begin
          // Counter registers and unmapped addresses ignore writes.
        end
      endcase
    end

    // A match in the same cycle as a clear keeps the flag set.
    nxt_state.compare_a_flag = (state_ff.compare_a_flag & ~clear_a) | set_a;
    nxt_state.compare_p_flag = (state_ff.compare_p_flag & ~clear_p) | set_p;

    // Read mux; unused bits and unmapped addresses read zero.
    if (i_read) begin
      unique case (i_address)
        `PTU_OFS_CONTROL_0: begin
          read_value[`PTU_C0_PAUSE_BIT] = state_ff.counter_pause;
          read_value[`PTU_C0_CLK_SEL_MSB:`PTU_C0_CLK_SEL_LSB] = state_ff.clock_source_select;
          read_value[`PTU_C0_ON_BIT] = state_ff.counter_on_off;
        end
        `PTU_OFS_CONTROL_1: begin
          read_value = {state_ff.mode_select, state_ff.pin_function,
                        state_ff.output_initial_level, state_ff.output_polarity_invert,
                        state_ff.capture_select, state_ff.counter_clear_select};
        end
        `PTU_OFS_COUNTER_LOW: begin
          read_value = state_ff.count[7:0];
        end
        `PTU_OFS_COUNTER_HIGH: begin
          read_value[1:0] = state_ff.count[9:8];
        end
        `PTU_OFS_COMPARE_A_LOW: begin
          read_value = state_ff.compare_a_value[7:0];
        end
        `PTU_OFS_COMPARE_A_HIGH: begin
          read_value[1:0] = state_ff.compare_a_value[9:8];
        end
        `PTU_OFS_COMPARE_P_LOW: begin
          read_value = state_ff.compare_p_value[7:0];
        end
        `PTU_OFS_COMPARE_P_HIGH: begin
          read_value[1:0] = state_ff.compare_p_value[9:8];
        end
        `PTU_OFS_FLAGS: begin
          read_value[`PTU_FLAG_A_BIT] = state_ff.compare_a_flag;
          read_value[`PTU_FLAG_P_BIT] = state_ff.compare_p_flag;
        end
        default: begin
          read_value = `PTU_RESET_BYTE;
        end
      endcase
    end
    nxt_state.read_data = read_value;
  end

  // ========================================================================
  // Registers.
  // ========================================================================

  // Every field resets to zero, so the struct clears as a whole.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_ff      <= '0;
      read_valid_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      read_valid_ff <= nxt_read_valid;
    end
  end

  // ========================================================================
  // Outputs, each straight from a flop.
  // ========================================================================

  // The pin carries out_level even while disabled; it is not forced low.
  assign o_read_data_valid = read_valid_ff;
  assign o_read_data       = state_ff.read_data;
  assign o_out_pin         = state_ff.out_level;
  assign o_out_enable      = state_ff.out_enable;
  assign o_compare_a_flag  = state_ff.compare_a_flag;
  assign o_compare_p_flag  = state_ff.compare_p_flag;

endmodule // ptu_timer

`default_nettype wire

// [ptu_timer_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Port-level checks of the periodic timer.
module ptu_timer_checker (
  input wire logic               i_clock, // Clock.
  input wire logic               i_reset, // Reset.
  input wire ptu_pkg::ptu_addr_t i_address, // Address.
  input wire ptu_pkg::ptu_byte_t i_write_data, // Write data.
  input wire logic               i_write, // Write strobe.
  input wire logic               i_read, // Read strobe.
  input wire logic               o_read_data_valid, // Read valid.
  input wire ptu_pkg::ptu_byte_t o_read_data, // Read data.
  input wire logic               o_out_pin, // Pin level.
  input wire logic               o_out_enable, // Pin enable.
  input wire logic               o_compare_a_flag, // Flag A.
  input wire logic               o_compare_p_flag // Flag P.
);
  import ptu_pkg::*;
  ptu_byte_t ctl1_ff;
  logic      clr_a;
  logic      clr_p;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  // Shadow of the mode register.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ctl1_ff <= 8'h00;
    end else if (i_write && i_address == 4'h1) begin
      ctl1_ff <= i_write_data;
    end
  end
  // Software clears; only their absence is checked.
  assign clr_a = i_write && i_address == 4'h8 && i_write_data[0];
  assign clr_p = i_write && i_address == 4'h8 && i_write_data[1];
  a_read_valid: assert property (o_read_data_valid == $past(i_read))
    else $error("read valid late");
  a_idle_zero: assert property (!o_read_data_valid |-> o_read_data == 8'h00)
    else $error("read data not zero");
  a_high_zero: assert property (
    i_read && i_address inside {4'h3, 4'h5, 4'h7} |=> o_read_data[7:2] == 6'h00)
    else $error("high bits set");
  a_unmapped_zero: assert property (
    i_read && i_address > 4'h8 |=> o_read_data == 8'h00) else $error("unmapped read");
  a_flag_a_sticky: assert property (
    o_compare_a_flag && !clr_a |=> o_compare_a_flag) else $error("flag a dropped");
  a_flag_p_sticky: assert property (
    o_compare_p_flag && !clr_p |=> o_compare_p_flag) else $error("flag p dropped");
  a_timer_pin_off: assert property (
    ctl1_ff[7:6] == 2'h3 && $past(ctl1_ff[7:6]) == 2'h3 |-> !o_out_enable)
    else $error("pin driven in timer mode");
  a_pin_toggle_a: assert property (
    ctl1_ff[7:4] == 4'h3 && $rose(o_compare_a_flag) |-> o_out_pin != $past(o_out_pin))
    else $error("no toggle on a match");
  a_p_keeps_pin: assert property (
    ctl1_ff[7:6] == 2'h0 && $rose(o_compare_p_flag) && !$rose(o_compare_a_flag)
    |-> $stable(o_out_pin)) else $error("pin moved on p match");
endmodule // ptu_timer_checker
bind ptu_timer ptu_timer_checker u_checker (
  .i_clock(i_clock), .i_reset(i_reset), .i_address(i_address),
  .i_write_data(i_write_data), .i_write(i_write), .i_read(i_read),
  .o_read_data_valid(o_read_data_valid), .o_read_data(o_read_data),
  .o_out_pin(o_out_pin), .o_out_enable(o_out_enable),
  .o_compare_a_flag(o_compare_a_flag), .o_compare_p_flag(o_compare_p_flag)
);
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Register-level timer test.
module tb;
  import ptu_pkg::*;
  logic      i_clock = 1'b0;
  logic      i_reset = 1'b1;
  ptu_addr_t i_address = 4'h0;
  ptu_byte_t i_write_data = 8'h00;
  logic      i_write = 1'b0;
  logic      i_read = 1'b0;
  logic      fire = 1'b0;
  logic      ext_pin;
  logic      sub_clk;
  logic      o_read_data_valid;
  ptu_byte_t o_read_data;
  logic      o_out_pin;
  logic      o_out_enable;
  logic      o_compare_a_flag;
  logic      o_compare_p_flag;
  int        errors = 0;
  int        num_checks = 0;
  ptu_byte_t d;
  ptu_byte_t e;
  int        n;
  int        dv [6] = '{4, 1, 16, 64, 8, 8};
  ptu_byte_t pc [6] = '{8'h88, 8'h98, 8'h9c, 8'h8c, 8'hac, 8'ha0};
  int        ph [6] = '{0, 40, 0, 40, 30, 30};
  // 50 MHz clock.
  always #10 i_clock = ~i_clock;
  ptu_timer dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_address(i_address),
    .i_write_data(i_write_data), .i_write(i_write), .i_read(i_read),
    .i_ext_clock_pin(ext_pin), .i_sub_clock(sub_clk),
    .o_read_data_valid(o_read_data_valid), .o_read_data(o_read_data),
    .o_out_pin(o_out_pin), .o_out_enable(o_out_enable),
    .o_compare_a_flag(o_compare_a_flag), .o_compare_p_flag(o_compare_p_flag)
  );
  ptu_pin_model u_pins (.i_clock(i_clock), .i_fire(fire), .o_pin(ext_pin), .o_sub(sub_clk));
  // ======================================
  // Shared tasks.
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input ptu_addr_t a, input ptu_byte_t v);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_address <= a;
    i_write_data <= v;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input ptu_addr_t a, output ptu_byte_t v);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_address <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1;
    v = o_read_data;
    chk(o_read_data_valid, 1, "read valid");
  endtask
  task automatic rc(input ptu_addr_t a, input logic [9:0] x, input string nm);
    rd(a, d);
    chk(d, x, nm);
  endtask
  task automatic go(input ptu_byte_t m);
    wr(4'h1, m);
    wr(4'h0, 8'h18);
  endtask
  task automatic span(input ptu_byte_t c);
    wr(4'h0, c);
    rd(4'h2, d);
    repeat (10) @(posedge i_clock);
    rd(4'h2, e);
  endtask
  // Stop and clear flags before a mode change.
  task automatic halt();
    wr(4'h0, 8'h10);
    wr(4'h8, 8'h03);
  endtask
  task automatic hi_cnt(input int len, input int x, input string nm);
    n = 0;
    repeat (8) @(posedge i_clock);
    repeat (len) begin
      @(posedge i_clock);
      #1;
      n += o_out_pin;
    end
    chk(n, x, nm);
  endtask
  task automatic wait_pin(input logic lvl, input string nm);
    repeat (200) if (o_out_pin !== lvl) @(posedge i_clock);
    #1;
    chk(o_out_pin, lvl, nm);
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog at about three times the expected run.
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
  // ======================================
  // Main sequence.
  initial begin
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int a = 0; a < 16; a++)
      rc(a[3:0], 10'h000, "reset value");
    wr(4'h5, 8'hff);
    wr(4'h7, 8'hfe);
    wr(4'h2, 8'h55);
    rc(4'h5, 10'h003, "compare a high");
    rc(4'h7, 10'h002, "compare p high");
    rc(4'h2, 10'h000, "counter write");
    // Compare: A=2, P=4, toggle, start high.
    wr(4'h5, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h4, 8'h02);
    wr(4'h6, 8'h04);
    go(8'h38);
    repeat (3) @(posedge i_clock);
    #1;
    chk(o_out_pin, 1, "initial level");
    repeat (20) if (!o_compare_a_flag) @(posedge i_clock);
    #1;
    chk(o_out_pin, 0, "pin after a match");
    repeat (20) if (!o_compare_p_flag) @(posedge i_clock);
    #1;
    chk(o_out_pin, 0, "pin after p match");
    rc(4'h8, 10'h003, "both flags");
    halt();
    rc(4'h8, 10'h000, "flags cleared");
    // Clear on A, P below A: no P flag.
    wr(4'h6, 8'h01);
    go(8'h39);
    repeat (60) @(posedge i_clock);
    rc(4'h8, 10'h001, "clear on a");
    // Both compares zero: the count wraps.
    halt();
    wr(4'h4, 8'h00);
    wr(4'h6, 8'h00);
    go(8'h38);
    repeat (600) @(posedge i_clock);
    rc(4'h3, 10'h002, "count past p zero");
    repeat (500) @(posedge i_clock);
    rc(4'h3, 10'h000, "wrapped count");
    rc(4'h8, 10'h000, "no flag at zero");
    span(8'h98);
    chk(e, d, "paused count");
    span(8'h18);
    chk(e != d, 1, "resumed count");
    span(8'h10);
    chk(e, d, "held count");
    wr(4'h0, 8'h18);
    rd(4'h2, d);
    chk(d < 8'h08, 1, "restart at zero");
    // Timer mode: flags, no pin.
    halt();
    wr(4'h4, 8'h03);
    go(8'hc0);
    repeat (20) @(posedge i_clock);
    chk(o_out_enable, 0, "timer enable");
    rc(4'h8, 10'h001, "timer flags");
    wr(4'h4, 8'h00);
    for (int s = 0; s < 6; s++) begin
      halt();
      wr(4'h0, {1'b0, s[2:0], 4'h8});
      repeat (512) @(posedge i_clock);
      wr(4'h0, {1'b0, s[2:0], 4'h0});
      rd(4'h2, d);
      rd(4'h3, e);
      n = {e[1:0], d};
      chk(n >= 512 / dv[s] - 3 && n <= 512 / dv[s] + 3, 1, "tick rate");
    end
    // PWM: P=4 A=1, full duty, then P=0 A=512.
    halt();
    wr(4'h4, 8'h01);
    wr(4'h6, 8'h04);
    go(8'ha8);
    hi_cnt(40, 10, "pwm duty");
    rc(4'h8, 10'h003, "pwm flags");
    wr(4'h4, 8'h05);
    hi_cnt(40, 40, "full duty");
    wr(4'h5, 8'h02);
    wr(4'h4, 8'h00);
    wr(4'h6, 8'h00);
    hi_cnt(1024, 512, "period 1024");
    wr(4'h4, 8'h01);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h04);
    for (int i = 0; i < 6; i++) begin
      halt();
      go(pc[i]);
      hi_cnt(40, ph[i], "pin function level");
      rc(4'h8, 10'h003, "forced level flags");
    end
    // Single pulse: A=6 ends it, P=4 is ignored.
    halt();
    wr(4'h4, 8'h06);
    go(8'hb8);
    repeat (3) @(posedge i_clock);
    #1;
    chk(o_out_pin, 1, "pulse lead");
    repeat (20) @(posedge i_clock);
    rd(4'h0, d);
    chk(d[3], 0, "on self clear");
    chk(o_out_pin, 0, "pulse trail");
    rc(4'h8, 10'h001, "pulse flag");
    for (int s = 6; s < 8; s++) begin
      repeat (80) @(posedge i_clock);
      wr(4'h8, 8'h03);
      wr(4'h0, {1'b0, s[2:0], 4'h0});
      fire <= 1'b1;
      @(posedge i_clock);
      fire <= 1'b0;
      wait_pin(1'b1, "pin trigger");
      wait_pin(1'b0, "trigger pulse end");
    end
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
